// File: rtl/uart_single_wire_pinsel.sv
// Serial port with baud prescaler, 9-bit frames and pin steering
//
// Functional notes
// RQ1: Frame select picks 8 or 9 data bits
// RQ2: Qualifier blocks receive flag when ninth bit zero
// RQ3: Receive enable steers shared pin direction
// RQ4: Ninth transmit bit sent in 9-bit mode
// RQ5: Ninth received bit captured in 9-bit mode
// RQ6: Transmit-done set when character sent
// RQ7: Receive-done set when character received
// RQ8: Flags cleared by writing zero only
// RQ9: Interrupt flag when either done flag set; code raises it only for a done flag whose mask_q bit is set
// RQ10: Bit rate is clock/16/prescaler
// RQ11: Single-wire select picks half or full duplex
// RQ12: Three transmit pin selects route transmit output
// RQ13: Three shared pin selects route receive/transmit
// RQ14: Data write transmits, read returns received
// RQ15: Start low, LSB first, ninth, stop high
// RQ16: Sixteen-fold sampling, centre bit sampling
module uart_single_wire_pinsel (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic [8:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Interrupt
   output logic serial_irq_flag,
   // Transmit-only pins
   output logic port_b_bit3_o,
   output logic port_b_bit3_oe,
   output logic port_b_bit1_o,
   output logic port_b_bit1_oe,
   output logic port_a_bit1_o,
   output logic port_a_bit1_oe,
   // Shared pins
   input wire logic port_b_bit0_i,
   output logic port_b_bit0_o,
   output logic port_b_bit0_oe,
   input wire logic port_a_bit5_i,
   output logic port_a_bit5_o,
   output logic port_a_bit5_oe,
   input wire logic port_a_bit0_i,
   output logic port_a_bit0_o,
   output logic port_a_bit0_oe
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   uart_pkg::ctrl_type ctrl_q;
   uart_pkg::pinsel_type pinsel_q;
   logic [7:0] baud_q;
   logic [7:0] mask_q;
   logic tx_done_q;
   logic rx_done_q;
   logic rx_ninth_q;
   logic [7:0] rx_buf_q;
   logic tx_set;
   logic rx_set;
   logic wr_ctrl;
   logic wr_data;
   assign wr_ctrl = reg_write && reg_addr == uart_pkg::serial_control_addr;
   assign wr_data = reg_write && reg_addr == uart_pkg::serial_data_buffer_addr;

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= uart_pkg::ctrl_type'({uart_pkg::ctrl_reset[7], uart_pkg::ctrl_reset[5:3]});
         baud_q <= uart_pkg::baud_reset;
         pinsel_q <= uart_pkg::pinsel_type'({uart_pkg::pinsel_reset[7], uart_pkg::pinsel_reset[5:0]});
         mask_q <= uart_pkg::mask_reset;
      end else if (reg_write) begin
         if (reg_addr == uart_pkg::serial_control_addr) begin
            ctrl_q.nine_bit_frame_sel <= reg_wdata[uart_pkg::nine_bit_frame_pos];
            ctrl_q.rx_flag_qualify <= reg_wdata[uart_pkg::rx_flag_qualify_pos];
            ctrl_q.receive_enable_bit <= reg_wdata[uart_pkg::receive_enable_pos];
            ctrl_q.tx_ninth_bit <= reg_wdata[uart_pkg::tx_ninth_pos];
         end
         if (reg_addr == uart_pkg::baud_prescaler_addr) begin
            baud_q <= reg_wdata;
         end
         if (reg_addr == uart_pkg::link_pin_select_addr) begin
            pinsel_q <= {reg_wdata[uart_pkg::single_wire_pos], reg_wdata[5:0]};
         end
         if (reg_addr == uart_pkg::irq_mask_addr) begin
            mask_q <= {6'h00, reg_wdata[1:0]};
         end
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_done_q <= 1'b0;
         rx_done_q <= 1'b0;
      end else begin
         if (tx_set) begin
            tx_done_q <= 1'b1; // RQ6
         end else if (wr_ctrl && !reg_wdata[uart_pkg::tx_done_pos]) begin
            tx_done_q <= 1'b0; // RQ8
         end
         if (rx_set) begin
            rx_done_q <= 1'b1; // RQ7
         end else if (wr_ctrl && !reg_wdata[uart_pkg::rx_done_pos]) begin
            rx_done_q <= 1'b0; // RQ8
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         serial_irq_flag <= 1'b0;
      end else begin
         serial_irq_flag <= (tx_done_q & mask_q[1]) | (rx_done_q & mask_q[0]); // RQ9
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            uart_pkg::serial_control_addr: reg_rdata <= {ctrl_q.nine_bit_frame_sel, 1'b0,
               ctrl_q.rx_flag_qualify, ctrl_q.receive_enable_bit, ctrl_q.tx_ninth_bit,
               rx_ninth_q, tx_done_q, rx_done_q};
            uart_pkg::serial_data_buffer_addr: reg_rdata <= rx_buf_q; // RQ14
            uart_pkg::baud_prescaler_addr: reg_rdata <= baud_q;
            uart_pkg::link_pin_select_addr: reg_rdata <= {pinsel_q.single_wire_sel, 1'b0,
               pinsel_q.tx_on_port_b3_sel, pinsel_q.tx_on_port_b1_sel, pinsel_q.tx_on_port_a1_sel,
               pinsel_q.shared_on_port_b0_sel, pinsel_q.shared_on_port_a5_sel,
               pinsel_q.shared_on_port_a0_sel};
            uart_pkg::irq_mask_addr: reg_rdata <= mask_q;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Oversample tick: clock / prescaler, 16 ticks a bit
   // ----------------------------------------
   logic [7:0] pre_q;
   logic tick;
   logic wr_baud;
   // Prescaler zero stops the port rather than dividing by 256
   assign tick = baud_q != 8'h00 && pre_q == baud_q - 8'h01;
   // Restart on a new prescaler, else a smaller value strands the count above it
   assign wr_baud = reg_write && reg_addr == uart_pkg::baud_prescaler_addr;
   always_ff @(posedge clock) begin
      if (rst || tick || wr_baud || baud_q == 8'h00) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01; // RQ10
      end
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   uart_pkg::line_state_type tx_st_q;
   logic [3:0] tx_os_q;
   logic [3:0] tx_bit_q;
   logic [8:0] tx_sh_q;
   logic tx_line_q;
   logic [3:0] nbits;
   assign nbits = ctrl_q.nine_bit_frame_sel ? 4'h9 : 4'h8; // RQ1

   always_ff @(posedge clock) begin
      if (rst) begin
         tx_st_q <= uart_pkg::st_idle;
         tx_os_q <= 4'h0;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 9'h000;
         tx_line_q <= 1'b1;
         tx_set <= 1'b0;
      end else begin
         tx_set <= 1'b0;
         case (tx_st_q)
            uart_pkg::st_idle: begin
               tx_line_q <= 1'b1; // RQ15
               if (wr_data) begin
                  tx_sh_q <= {ctrl_q.tx_ninth_bit, reg_wdata}; // RQ4 RQ14
                  tx_os_q <= 4'h0;
                  tx_bit_q <= 4'h0;
                  tx_st_q <= uart_pkg::st_start;
               end
            end
            uart_pkg::st_start: begin
               tx_line_q <= 1'b0; // RQ15
               if (tick) begin
                  tx_os_q <= tx_os_q + 4'h1;
                  if (tx_os_q == uart_pkg::oversample_last) begin
                     tx_st_q <= uart_pkg::st_data;
                  end
               end
            end
            uart_pkg::st_data: begin
               tx_line_q <= tx_sh_q[0];
               if (tick) begin
                  tx_os_q <= tx_os_q + 4'h1;
                  if (tx_os_q == uart_pkg::oversample_last) begin
                     tx_sh_q <= {1'b1, tx_sh_q[8:1]};
                     tx_bit_q <= tx_bit_q + 4'h1;
                     if (tx_bit_q == nbits - 4'h1) begin
                        tx_st_q <= uart_pkg::st_stop;
                     end
                  end
               end
            end
            uart_pkg::st_stop: begin
               tx_line_q <= 1'b1;
               if (tick) begin
                  tx_os_q <= tx_os_q + 4'h1;
                  if (tx_os_q == uart_pkg::oversample_last) begin
                     tx_set <= 1'b1; // RQ6
                     tx_st_q <= uart_pkg::st_idle;
                  end
               end
            end
            default: tx_st_q <= uart_pkg::st_idle;
         endcase
      end
   end

   // ----------------------------------------
   // Receive pin selection and synchroniser
   // ----------------------------------------
   logic [2:0] pin_meta_q;
   logic [2:0] pin_sync_q;
   logic rx_line;
   logic rx_path_on;
   always_ff @(posedge clock) begin
      if (rst) begin
         pin_meta_q <= 3'b111;
         pin_sync_q <= 3'b111;
      end else begin
         pin_meta_q <= {port_b_bit0_i, port_a_bit5_i, port_a_bit0_i};
         pin_sync_q <= pin_meta_q;
      end
   end
   // Several selected pins are ANDed: any low pulls the line low
   assign rx_line = (pin_sync_q[2] | ~pinsel_q.shared_on_port_b0_sel)
      & (pin_sync_q[1] | ~pinsel_q.shared_on_port_a5_sel)
      & (pin_sync_q[0] | ~pinsel_q.shared_on_port_a0_sel); // RQ13
   assign rx_path_on = ctrl_q.receive_enable_bit; // RQ3

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   uart_pkg::line_state_type rx_st_q;
   logic [3:0] rx_os_q;
   logic [3:0] rx_bit_q;
   logic [8:0] rx_sh_q;
   logic rx_prev_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_st_q <= uart_pkg::st_idle;
         rx_os_q <= 4'h0;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 9'h000;
         rx_prev_q <= 1'b1;
         rx_buf_q <= 8'h00;
         rx_ninth_q <= 1'b0;
         rx_set <= 1'b0;
      end else begin
         rx_set <= 1'b0;
         if (tick) begin
            rx_prev_q <= rx_line;
         end
         if (!rx_path_on) begin
            rx_st_q <= uart_pkg::st_idle;
         end else if (tick) begin
            case (rx_st_q)
               uart_pkg::st_idle: begin
                  if (rx_prev_q && !rx_line) begin
                     rx_os_q <= 4'h0; // RQ16
                     rx_bit_q <= 4'h0;
                     rx_st_q <= uart_pkg::st_start;
                  end
               end
               uart_pkg::st_start: begin
                  rx_os_q <= rx_os_q + 4'h1;
                  if (rx_os_q == uart_pkg::sample_mid) begin
                     rx_os_q <= 4'h0;
                     rx_st_q <= rx_line ? uart_pkg::st_idle : uart_pkg::st_data;
                  end
               end
               uart_pkg::st_data: begin
                  rx_os_q <= rx_os_q + 4'h1;
                  if (rx_os_q == uart_pkg::oversample_last) begin
                     rx_sh_q <= {rx_line, rx_sh_q[8:1]}; // RQ16
                     rx_bit_q <= rx_bit_q + 4'h1;
                     if (rx_bit_q == nbits - 4'h1) begin
                        rx_st_q <= uart_pkg::st_stop;
                     end
                  end
               end
               uart_pkg::st_stop: begin
                  rx_os_q <= rx_os_q + 4'h1;
                  if (rx_os_q == uart_pkg::oversample_last) begin
                     rx_st_q <= uart_pkg::st_idle;
                     if (ctrl_q.nine_bit_frame_sel) begin
                        rx_buf_q <= rx_sh_q[7:0];
                        rx_ninth_q <= rx_sh_q[8]; // RQ5
                        rx_set <= !(ctrl_q.rx_flag_qualify && !rx_sh_q[8]); // RQ2 RQ7
                     end else begin
                        rx_buf_q <= rx_sh_q[8:1];
                        rx_set <= 1'b1; // RQ7
                     end
                  end
               end
               default: rx_st_q <= uart_pkg::st_idle;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Pin steering
   // ----------------------------------------
   logic shared_tx;
   assign shared_tx = pinsel_q.single_wire_sel && !ctrl_q.receive_enable_bit; // RQ3 RQ11
   always_ff @(posedge clock) begin
      if (rst) begin
         port_b_bit3_o <= 1'b1;
         port_b_bit3_oe <= 1'b0;
         port_b_bit1_o <= 1'b1;
         port_b_bit1_oe <= 1'b0;
         port_a_bit1_o <= 1'b1;
         port_a_bit1_oe <= 1'b0;
         port_b_bit0_o <= 1'b1;
         port_b_bit0_oe <= 1'b0;
         port_a_bit5_o <= 1'b1;
         port_a_bit5_oe <= 1'b0;
         port_a_bit0_o <= 1'b1;
         port_a_bit0_oe <= 1'b0;
      end else begin
         port_b_bit3_o <= tx_line_q;
         port_b_bit3_oe <= pinsel_q.tx_on_port_b3_sel; // RQ12
         port_b_bit1_o <= tx_line_q;
         port_b_bit1_oe <= pinsel_q.tx_on_port_b1_sel; // RQ12
         port_a_bit1_o <= tx_line_q;
         port_a_bit1_oe <= pinsel_q.tx_on_port_a1_sel; // RQ12
         port_b_bit0_o <= tx_line_q;
         port_b_bit0_oe <= pinsel_q.shared_on_port_b0_sel && shared_tx; // RQ13
         port_a_bit5_o <= tx_line_q;
         port_a_bit5_oe <= pinsel_q.shared_on_port_a5_sel && shared_tx; // RQ13
         port_a_bit0_o <= tx_line_q;
         port_a_bit0_oe <= pinsel_q.shared_on_port_a0_sel && shared_tx; // RQ13
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_TX_SET: assert property (@(posedge clock) disable iff (rst) tx_set |=> tx_done_q) // RQ6
      else $error("transmit done not set");
   AST_RX_SET: assert property (@(posedge clock) disable iff (rst) rx_set |=> rx_done_q) // RQ7
      else $error("receive done not set");
   AST_W1_KEEP: assert property (@(posedge clock) disable iff (rst)
      (wr_ctrl && reg_wdata[uart_pkg::tx_done_pos] && !tx_set) |=> tx_done_q == $past(tx_done_q)) // RQ8
      else $error("write one changed transmit done");
   AST_W0_CLR: assert property (@(posedge clock) disable iff (rst)
      (wr_ctrl && !reg_wdata[uart_pkg::rx_done_pos] && !rx_set) |=> !rx_done_q) // RQ8
      else $error("write zero did not clear receive done");
   AST_IRQ: assert property (@(posedge clock) disable iff (rst)
      (rx_done_q && mask_q[0]) |=> serial_irq_flag) // RQ9
      else $error("interrupt missing");
   AST_QUAL: assert property (@(posedge clock) disable iff (rst)
      (ctrl_q.nine_bit_frame_sel && ctrl_q.rx_flag_qualify && rx_st_q == uart_pkg::st_stop && tick
       && rx_os_q == uart_pkg::oversample_last && !rx_sh_q[8]) |=> !rx_set) // RQ2
      else $error("qualified flag raised with ninth bit zero");
   AST_TX_START: assert property (@(posedge clock) disable iff (rst)
      (wr_data && tx_st_q == uart_pkg::st_idle) |=> ##1 !tx_line_q) // RQ15
      else $error("start bit not low");
   AST_SHARED_DIR: assert property (@(posedge clock) disable iff (rst)
      ctrl_q.receive_enable_bit |=> !port_b_bit0_oe && !port_a_bit5_oe && !port_a_bit0_oe) // RQ3
      else $error("shared pin driven while receiving");
   AST_TXPIN: assert property (@(posedge clock) disable iff (rst)
      pinsel_q.tx_on_port_b3_sel |=> port_b_bit3_oe) // RQ12
      else $error("transmit pin not enabled");
   AST_TICK: assert property (@(posedge clock) disable iff (rst) // RQ10
      (tick && baud_q == 8'h02 && !wr_baud) ##1 !wr_baud |-> !tick ##1 tick)
      else $error("prescaler period wrong");
   COV_TX: cover property (@(posedge clock) disable iff (rst) tx_set);
   COV_RX: cover property (@(posedge clock) disable iff (rst) rx_set);
   COV_NINE: cover property (@(posedge clock) disable iff (rst) rx_set && ctrl_q.nine_bit_frame_sel);
endmodule // uart_single_wire_pinsel

// File: shared/uart_pkg.sv
// Shared constants and types for the single-wire serial port
package uart_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [8:0] serial_control_addr = 9'h195;
   localparam logic [8:0] serial_data_buffer_addr = 9'h196;
   localparam logic [8:0] baud_prescaler_addr = 9'h197;
   localparam logic [8:0] link_pin_select_addr = 9'h198;
   localparam logic [8:0] irq_mask_addr = 9'h199;
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [7:0] baud_reset = 8'h00;
   localparam logic [7:0] pinsel_reset = 8'h00;
   localparam logic [7:0] mask_reset = 8'h00;
   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int nine_bit_frame_pos = 7;
   localparam int rx_flag_qualify_pos = 5;
   localparam int receive_enable_pos = 4;
   localparam int tx_ninth_pos = 3;
   localparam int rx_ninth_pos = 2;
   localparam int tx_done_pos = 1;
   localparam int rx_done_pos = 0;
   localparam int single_wire_pos = 7;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam logic [3:0] oversample_last = 4'hf;
   localparam logic [3:0] sample_mid = 4'h7;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_start = 2'b01,
      st_data = 2'b10,
      st_stop = 2'b11
   } line_state_type;
   typedef struct packed {
      logic nine_bit_frame_sel;
      logic rx_flag_qualify;
      logic receive_enable_bit;
      logic tx_ninth_bit;
   } ctrl_type;
   typedef struct packed {
      logic single_wire_sel;
      logic tx_on_port_b3_sel;
      logic tx_on_port_b1_sel;
      logic tx_on_port_a1_sel;
      logic shared_on_port_b0_sel;
      logic shared_on_port_a5_sel;
      logic shared_on_port_a0_sel;
   } pinsel_type;
endpackage

// File: test/remote_serial.sv
// Behavioural model of the remote serial device on the port's pins
module remote_serial (
   // Clock
   input wire logic clock,
   // Lines
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial line_out = 1'b1;

   // Start bit, LSB-first data, stop bit; released line is high
   task automatic send_char(input logic [8:0] v, input int n, input int bitc);
      @(posedge clock);
      line_out <= 1'b0;
      repeat (bitc) @(posedge clock);
      for (int i = 0; i < n; i++) begin
         line_out <= v[i];
         repeat (bitc) @(posedge clock);
      end
      line_out <= 1'b1;
      repeat (bitc) @(posedge clock);
   endtask

   // Samples mid-bit from the falling edge; ok clears on bad start or stop
   task automatic recv_char(output logic [8:0] v, output logic ok, input int n, input int bitc);
      int w;
      v = 9'h000;
      ok = 1'b0;
      w = 0;
      while (line_in !== 1'b0 && w < 2000) begin
         @(negedge clock);
         w++;
      end
      if (w >= 2000) return;
      repeat (bitc / 2) @(negedge clock);
      ok = (line_in === 1'b0);
      for (int i = 0; i < n; i++) begin
         repeat (bitc) @(negedge clock);
         v[i] = line_in;
      end
      repeat (bitc) @(negedge clock);
      ok = ok && (line_in === 1'b1);
   endtask
endmodule // remote_serial

// File: test/tb_uart_single_wire_pinsel.sv
// Self-checking testbench for the serial port with pin steering
module tb_uart_single_wire_pinsel;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock, rst, reg_write, reg_read;
   logic [8:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic serial_irq_flag;
   logic b3_o, b3_oe, b1_o, b1_oe, a1_o, a1_oe;
   logic b0_o, b0_oe, a5_o, a5_oe, a0_o, a0_oe;
   logic b0_i, a5_i, a0_i, rline, mon_line;
   logic [1:0] mon_sel;
   int n_fail = 0;
   int tests_run = 0;

   // Shared pins: the driving party wins, else the remote's line
   assign b0_i = b0_oe ? b0_o : rline;
   assign a5_i = a5_oe ? a5_o : rline;
   assign a0_i = a0_oe ? a0_o : rline;
   // Undriven pins are pulled high
   assign mon_line = (mon_sel == 2'd0) ? (b3_oe ? b3_o : 1'b1) :
                     (mon_sel == 2'd1) ? (a1_oe ? a1_o : 1'b1) : (a0_oe ? a0_o : 1'b1);

   uart_single_wire_pinsel dut (
      .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .serial_irq_flag(serial_irq_flag),
      .port_b_bit3_o(b3_o), .port_b_bit3_oe(b3_oe), .port_b_bit1_o(b1_o), .port_b_bit1_oe(b1_oe),
      .port_a_bit1_o(a1_o), .port_a_bit1_oe(a1_oe),
      .port_b_bit0_i(b0_i), .port_b_bit0_o(b0_o), .port_b_bit0_oe(b0_oe),
      .port_a_bit5_i(a5_i), .port_a_bit5_o(a5_o), .port_a_bit5_oe(a5_oe),
      .port_a_bit0_i(a0_i), .port_a_bit0_o(a0_o), .port_a_bit0_oe(a0_oe)
   );

   remote_serial remote (.clock(clock), .line_in(mon_line), .line_out(rline));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ----------------------------------------
   // Bus and checking helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] r;
      rd(a, r);
      check(r, exp, msg);
   endtask

   // By reference: the pin is judged after it settles, not when the call is made
   task automatic pin_chk(ref logic got, input logic exp, input string msg);
      repeat (3) @(negedge clock);
      check({7'h00, got}, {7'h00, exp}, msg);
   endtask

   // Launches one character and captures it on the monitored pin
   task automatic do_tx(input logic [7:0] ctrl, input logic [8:0] v, input int n, input int bitc);
      logic [8:0] got;
      logic ok;
      fork
         wr(uart_pkg::serial_data_buffer_addr, v[7:0]);
         remote.recv_char(got, ok, n, bitc);
      join
      check({7'h00, ok}, 8'h01, "frame shape");
      check(got[7:0], v[7:0], "tx data");
      check({7'h00, got[8]}, {7'h00, v[8]}, "tx ninth");
      repeat (bitc) @(posedge clock);
      rd_chk(uart_pkg::serial_control_addr, ctrl | 8'h02, "tx done");
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd_chk(uart_pkg::serial_control_addr, 8'h00, "ctrl reset");
      rd_chk(uart_pkg::baud_prescaler_addr, 8'h00, "baud reset");
      rd_chk(uart_pkg::link_pin_select_addr, 8'h00, "pinsel reset");
      rd_chk(uart_pkg::irq_mask_addr, 8'h00, "mask reset");
      wr(uart_pkg::link_pin_select_addr, 8'hff);
      rd_chk(uart_pkg::link_pin_select_addr, 8'hbf, "pinsel reserved");
      wr(uart_pkg::irq_mask_addr, 8'hff);
      rd_chk(uart_pkg::irq_mask_addr, 8'h03, "mask width");
      wr(9'h1a0, 8'h5a);
      rd_chk(9'h1a0, 8'h00, "unmapped");
      wr(uart_pkg::irq_mask_addr, 8'h00);
   endtask

   task automatic t_tx8_irq();
      mon_sel = 2'd0;
      wr(uart_pkg::baud_prescaler_addr, 8'h01);
      wr(uart_pkg::link_pin_select_addr, 8'h20);
      wr(uart_pkg::serial_control_addr, 8'h00);
      pin_chk(b3_oe, 1'b1, "b3 oe");
      pin_chk(b1_oe, 1'b0, "b1 oe");
      pin_chk(b1_o, 1'b1, "b1 idle high");
      do_tx(8'h00, 9'h0a5, 8, 16);
      pin_chk(serial_irq_flag, 1'b0, "irq masked");
      wr(uart_pkg::irq_mask_addr, 8'h02);
      pin_chk(serial_irq_flag, 1'b1, "irq tx");
      wr(uart_pkg::serial_control_addr, 8'h03);
      rd_chk(uart_pkg::serial_control_addr, 8'h02, "write one keeps");
      wr(uart_pkg::serial_control_addr, 8'h00);
      rd_chk(uart_pkg::serial_control_addr, 8'h00, "write zero clears");
      pin_chk(serial_irq_flag, 1'b0, "irq cleared");
   endtask

   task automatic t_tx9_slow();
      mon_sel = 2'd1;
      wr(uart_pkg::baud_prescaler_addr, 8'h02);
      wr(uart_pkg::link_pin_select_addr, 8'h08);
      wr(uart_pkg::serial_control_addr, 8'h88);
      pin_chk(a1_oe, 1'b1, "a1 oe");
      pin_chk(b3_oe, 1'b0, "b3 off");
      do_tx(8'h88, 9'h15a, 9, 32);
      wr(uart_pkg::serial_control_addr, 8'h00);
   endtask

   task automatic t_rx();
      wr(uart_pkg::baud_prescaler_addr, 8'h01);
      wr(uart_pkg::link_pin_select_addr, 8'h04);
      wr(uart_pkg::irq_mask_addr, 8'h01);
      pin_chk(b0_oe, 1'b0, "b0 input");
      remote.send_char(9'h0f0, 8, 16);
      repeat (4) @(posedge clock);
      rd_chk(uart_pkg::serial_control_addr, 8'h00, "rx disabled");
      wr(uart_pkg::serial_control_addr, 8'h10);
      remote.send_char(9'h03c, 8, 16);
      repeat (4) @(posedge clock);
      rd_chk(uart_pkg::serial_control_addr, 8'h11, "rx done");
      pin_chk(serial_irq_flag, 1'b1, "irq rx");
      rd_chk(uart_pkg::serial_data_buffer_addr, 8'h3c, "rx data");
   endtask

   task automatic t_rx9_qual();
      wr(uart_pkg::serial_control_addr, 8'hb0);
      remote.send_char(9'h0c3, 9, 16);
      repeat (4) @(posedge clock);
      rd_chk(uart_pkg::serial_control_addr, 8'hb0, "qualified off");
      rd_chk(uart_pkg::serial_data_buffer_addr, 8'hc3, "rx9 data");
      remote.send_char(9'h1e1, 9, 16);
      repeat (4) @(posedge clock);
      rd_chk(uart_pkg::serial_control_addr, 8'hb5, "rx ninth");
      rd_chk(uart_pkg::serial_data_buffer_addr, 8'he1, "rx9 data");
      wr(uart_pkg::serial_control_addr, 8'h00);
   endtask

   task automatic t_single();
      mon_sel = 2'd2;
      wr(uart_pkg::link_pin_select_addr, 8'h81);
      pin_chk(a0_oe, 1'b1, "a0 drives");
      pin_chk(a5_oe, 1'b0, "a5 idle");
      // Ninth bit of the last 9-bit frame stays, 8-bit frames leave it alone
      do_tx(8'h04, 9'h096, 8, 16);
      wr(uart_pkg::serial_control_addr, 8'h10);
      pin_chk(a0_oe, 1'b0, "a0 receives");
      remote.send_char(9'h04b, 8, 16);
      repeat (4) @(posedge clock);
      rd_chk(uart_pkg::serial_data_buffer_addr, 8'h4b, "single rx");
   endtask

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic print_verdict();
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 9'h000;
      reg_wdata = 8'h00;
      mon_sel = 2'd0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_tx8_irq();
      t_tx9_slow();
      t_rx();
      t_rx9_qual();
      t_single();
      print_verdict();
   end
endmodule // tb_uart_single_wire_pinsel
